// file: drive_fault_annunciator.sv
// Fault annunciator: sorts fault conditions into warnings, trips and
// trip locks, latches trips until reset, drives five status LEDs.
// Assumes fault and panel pins are asynchronous, ain_level is on clk.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module drive_fault_annunciator #(
    parameter int unsigned esc_cycles = drive_fault_pkg::ESC_CYCLES,
    parameter int          ain_width  = 16
) (
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    // Fault sources and panel pins
    input  wire logic [127:0]          fault_raw,
    input  wire logic [7:0]            pin_raw,
    input  wire logic [ain_width-1:0]  ain_level,
    // AXI4-Lite write
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // LEDs and drive control
    output logic                       status_led,
    output logic                       bus_led,
    output logic                       alarm_led,
    output logic                       warn_led,
    output logic                       power_led,
    output logic                       coast,
    output logic                       ready
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [127:0]          f1, f2, f3, ff;
        logic [7:0]            p1, p2, p3, pf, pprev;
        logic [127:0]          trip;
        logic [127:0]          lock;
        logic                  armed;
        logic [31:0]           esc_cnt;
        logic [31:0]           slow_cnt, fast_cnt;
        logic                  slow_ph, fast_ph;
        logic                  auto_rst, three_ph, ser_rst;
        logic [1:0]            status_sel;
        logic [63:0]           alarm_sel;
        logic [ain_width-1:0]  min_scale;
        logic [31:0]           slow_half, fast_half;
        logic                  aw_full, w_full;
        logic [7:0]            waddr;
        logic [31:0]           wbuf;
        logic [3:0]            sbuf;
        logic                  awready, wready, bvalid, arready, rvalid;
        logic [1:0]            bresp, rresp;
        logic [31:0]           rdata;
        logic                  status_led, bus_led, alarm_led, warn_led;
        logic                  power_led, coast, ready;
    } state_type;

    state_type s;
    state_type next_s;
    logic [127:0] cond;
    logic         warn_any;
    logic         rst_req;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [2:0]  cls;
        logic        direct;
        logic        tset;
        logic        clr;
        logic        esc_hit;
        logic        pwr;
        logic [31:0] rd;
        logic [31:0] ctl;
        cls     = '0;
        direct  = 1'b0;
        tset    = 1'b0;
        clr     = 1'b0;
        rd      = '0;
        ctl     = '0;
        esc_hit = 1'b0;
        pwr     = 1'b0;
        next_s  = s;
        // Three-stage pin sync; accept once stages two and three agree
        next_s.f1 = fault_raw;
        next_s.f2 = s.f1;
        next_s.f3 = s.f2;
        next_s.ff = (s.f2 == s.f3) ? s.f3 : s.ff;
        next_s.p1 = pin_raw;
        next_s.p2 = s.p1;
        next_s.p3 = s.p2;
        next_s.pf = (s.p2 == s.p3) ? s.p3 : s.pf;
        next_s.pprev   = s.pf;
        next_s.ser_rst = 1'b0;
        pwr = s.pf[drive_fault_pkg::PIN_LINE] | s.pf[drive_fault_pkg::PIN_AUX];

        // Fault conditions
        cond = s.ff;
        cond[drive_fault_pkg::CODE_LIVE_ZERO] = s.ff[drive_fault_pkg::CODE_LIVE_ZERO]
            | (ain_level < (s.min_scale >> 1));
        cond[drive_fault_pkg::CODE_PHASE] = s.ff[drive_fault_pkg::CODE_PHASE] & s.three_ph;

        esc_hit = s.ff[drive_fault_pkg::CODE_VHIGH] && (s.esc_cnt == 32'(esc_cycles));
        if (!s.ff[drive_fault_pkg::CODE_VHIGH]) begin
            next_s.esc_cnt = '0;
        end else if (!esc_hit) begin
            next_s.esc_cnt = s.esc_cnt + 32'h0000_0001;
        end

        rst_req = (s.pf[drive_fault_pkg::PIN_KEY] & ~s.pprev[drive_fault_pkg::PIN_KEY])
                | (s.pf[drive_fault_pkg::PIN_DIN] & ~s.pprev[drive_fault_pkg::PIN_DIN])
                | s.ser_rst | s.auto_rst;

        // Per-code classification and trip latching
        warn_any = 1'b0;
        for (int c = 0; c < drive_fault_pkg::N_CODES; c++) begin
            cls = drive_fault_pkg::fault_class(7'(c));
            direct = cls[drive_fault_pkg::CLS_A] & (~cls[drive_fault_pkg::CLS_W]
                   | ((c < drive_fault_pkg::N_SEL)
                      ? s.alarm_sel[c % drive_fault_pkg::N_SEL] : 1'b0));
            tset = cond[c] & direct;
            if (c == drive_fault_pkg::CODE_OVERVOLT) begin
                tset = tset | esc_hit;
            end
            // Both LEDs while the tripping fault stays
            warn_any = warn_any | (cond[c] & cls[drive_fault_pkg::CLS_W] & ~direct)
                     | (s.trip[c] & cond[c]) | s.lock[c];
            // Lock needs power cycle before reset
            clr = rst_req & ~cond[c] & (~s.lock[c] | s.armed);
            // Trips held until reset; set wins
            next_s.trip[c] = tset | (s.trip[c] & ~clr);
            next_s.lock[c] = (tset & cls[drive_fault_pkg::CLS_L]) | (s.lock[c] & ~clr);
        end
        // Arm lock release on supply loss
        next_s.armed = (|s.lock) & (s.armed | ~pwr);

        if (s.slow_cnt >= s.slow_half) begin
            next_s.slow_cnt = '0;
            next_s.slow_ph  = ~s.slow_ph;
        end else begin
            next_s.slow_cnt = s.slow_cnt + 32'h0000_0001;
        end
        if (s.fast_cnt >= s.fast_half) begin
            next_s.fast_cnt = '0;
            next_s.fast_ph  = ~s.fast_ph;
        end else begin
            next_s.fast_cnt = s.fast_cnt + 32'h0000_0001;
        end

        next_s.alarm_led = (|s.trip) & s.slow_ph;
        next_s.warn_led  = warn_any & s.slow_ph;
        next_s.power_led = pwr;
        next_s.coast = |s.trip;
        next_s.ready = ~(|s.trip);
        case (s.status_sel)
            2'h1:    next_s.status_led = |s.trip;
            2'h2:    next_s.status_led = warn_any;
            2'h3:    next_s.status_led = (|s.trip) | warn_any;
            default: next_s.status_led = 1'b0;
        endcase
        if (!s.pf[drive_fault_pkg::PIN_BFIT]) begin
            next_s.bus_led = 1'b0;
        end else if (s.pf[drive_fault_pkg::PIN_BLOC]) begin
            next_s.bus_led = s.slow_ph;
        end else if (s.pf[drive_fault_pkg::PIN_BNOM]) begin
            next_s.bus_led = s.fast_ph;
        end else begin
            next_s.bus_led = s.pf[drive_fault_pkg::PIN_BOK];
        end

        // Write channel: address and data taken in either order
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.waddr   = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.wbuf   = wdata;
            next_s.sbuf   = wstrb;
        end
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = drive_fault_pkg::RESP_OKAY;
            ctl = {27'h0, 1'b0, s.status_sel, s.three_ph, s.auto_rst};
            if (s.waddr == drive_fault_pkg::OFS_CTRL) begin
                ctl = drive_fault_pkg::wmerge(ctl, s.wbuf, s.sbuf);
                next_s.auto_rst   = ctl[drive_fault_pkg::CTRL_AUTO];
                next_s.three_ph   = ctl[drive_fault_pkg::CTRL_3PH];
                next_s.status_sel = ctl[drive_fault_pkg::CTRL_SSEL +: 2];
                next_s.ser_rst    = ctl[drive_fault_pkg::CTRL_SRST];
            end else if (s.waddr == drive_fault_pkg::OFS_ASEL_LO) begin
                next_s.alarm_sel[31:0] = drive_fault_pkg::wmerge(s.alarm_sel[31:0],
                                                                 s.wbuf, s.sbuf);
            end else if (s.waddr == drive_fault_pkg::OFS_ASEL_HI) begin
                next_s.alarm_sel[63:32] = drive_fault_pkg::wmerge(s.alarm_sel[63:32],
                                                                  s.wbuf, s.sbuf);
            end else if (s.waddr == drive_fault_pkg::OFS_MIN_SCALE) begin
                ctl = drive_fault_pkg::wmerge(32'(s.min_scale), s.wbuf, s.sbuf);
                next_s.min_scale = ctl[ain_width-1:0];
            end else if (s.waddr == drive_fault_pkg::OFS_SLOW_HALF) begin
                next_s.slow_half = drive_fault_pkg::wmerge(s.slow_half, s.wbuf, s.sbuf);
            end else if (s.waddr == drive_fault_pkg::OFS_FAST_HALF) begin
                next_s.fast_half = drive_fault_pkg::wmerge(s.fast_half, s.wbuf, s.sbuf);
            end else if (s.waddr == drive_fault_pkg::OFS_STATUS
                      || (s.waddr >= drive_fault_pkg::OFS_TRIP0
                       && s.waddr <= drive_fault_pkg::OFS_TRIP3 && s.waddr[1:0] == 2'h0)) begin
                next_s.bresp = drive_fault_pkg::RESP_OKAY;  // Read-only, write ignored
            end else begin
                next_s.bresp = drive_fault_pkg::RESP_SLVERR;
            end
        end
        next_s.awready = ~next_s.aw_full & ~next_s.bvalid;
        next_s.wready  = ~next_s.w_full & ~next_s.bvalid;

        // Read channel
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = drive_fault_pkg::RESP_OKAY;
            if (araddr == drive_fault_pkg::OFS_CTRL) begin
                rd = {28'h0, s.status_sel, s.three_ph, s.auto_rst};
            end else if (araddr == drive_fault_pkg::OFS_ASEL_LO) begin
                rd = s.alarm_sel[31:0];
            end else if (araddr == drive_fault_pkg::OFS_ASEL_HI) begin
                rd = s.alarm_sel[63:32];
            end else if (araddr == drive_fault_pkg::OFS_MIN_SCALE) begin
                rd = 32'(s.min_scale);
            end else if (araddr == drive_fault_pkg::OFS_SLOW_HALF) begin
                rd = s.slow_half;
            end else if (araddr == drive_fault_pkg::OFS_FAST_HALF) begin
                rd = s.fast_half;
            end else if (araddr == drive_fault_pkg::OFS_STATUS) begin
                rd[drive_fault_pkg::STAT_TRIP]  = |s.trip;
                rd[drive_fault_pkg::STAT_LOCK]  = |s.lock;
                rd[drive_fault_pkg::STAT_WARN]  = warn_any;
                rd[drive_fault_pkg::STAT_ARMED] = s.armed;
                rd[drive_fault_pkg::STAT_POWER] = pwr;
            end else if (araddr >= drive_fault_pkg::OFS_TRIP0
                      && araddr <= drive_fault_pkg::OFS_TRIP3 && araddr[1:0] == 2'h0) begin
                rd = s.trip[32*((araddr - drive_fault_pkg::OFS_TRIP0) >> 2) +: 32];
            end else begin
                next_s.rresp = drive_fault_pkg::RESP_SLVERR;
            end
            next_s.rdata = rd;
        end
        next_s.arready = ~next_s.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s           <= '0;
            s.slow_half <= drive_fault_pkg::SLOW_HALF_RST;
            s.fast_half <= drive_fault_pkg::FAST_HALF_RST;
            s.ready     <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign awready    = s.awready;
    assign wready     = s.wready;
    assign bvalid     = s.bvalid;
    assign bresp      = s.bresp;
    assign arready    = s.arready;
    assign rvalid     = s.rvalid;
    assign rdata      = s.rdata;
    assign rresp      = s.rresp;
    assign status_led = s.status_led;
    assign bus_led    = s.bus_led;
    assign alarm_led  = s.alarm_led;
    assign warn_led   = s.warn_led;
    assign power_led  = s.power_led;
    assign coast      = s.coast;
    assign ready      = s.ready;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence no_trip_s;
        ce && !(|s.trip);
    endsequence
    sequence tune_clear_s;
        ce && s.auto_rst && s.trip[50] && !cond[50];
    endsequence

    alarm_led_off_a: assert property (no_trip_s |=> !alarm_led)
        else $error("alarm LED lit with no trip");
    warn_led_off_a: assert property (ce && !warn_any |=> !warn_led)
        else $error("warning LED lit with no warning");
    power_led_a: assert property (ce |=> power_led
        == $past(s.pf[drive_fault_pkg::PIN_LINE] | s.pf[drive_fault_pkg::PIN_AUX]))
        else $error("power LED disagrees with supplies");
    bus_absent_a: assert property (ce && !s.pf[drive_fault_pkg::PIN_BFIT] |=> !bus_led)
        else $error("bus LED lit without bus option");
    lock_hold_a: assert property (ce && (|s.lock) && !s.armed |=> (|s.lock))
        else $error("trip lock cleared before power cycle");
    warn_only_a: assert property (!(s.trip[5] | s.trip[6] | s.trip[33] | s.trip[99]))
        else $error("warning-only code tripped");
    never_lock_a: assert property (!(s.lock[10] | s.lock[36] | s.lock[50]))
        else $error("non-locking code locked");
    coast_trip_a: assert property (ce && (|s.trip) |=> coast && !ready)
        else $error("no coast while tripped");
    auto_clear_a: assert property (tune_clear_s |=> !s.trip[50])
        else $error("automatic reset did not clear trip");
    status_off_a: assert property ((no_trip_s and !warn_any) |=> !status_led)
        else $error("status LED lit while healthy");

endmodule : drive_fault_annunciator

`default_nettype wire

// file: drive_fault_pkg.sv
// Shared constants for the drive fault annunciator: register map,
// field positions, reset values, pin indices, timing and fault classes.
// Assumes a 250 MHz system clock and 32-bit AXI4-Lite register access.
package drive_fault_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam longint CLK_MHZ      = 250;
    localparam longint ESC_TIME_MS  = 5000;  // Least overvoltage escalation time
    localparam int unsigned ESC_CYCLES = 32'(ESC_TIME_MS * 1000 * CLK_MHZ);
    localparam logic [31:0] SLOW_HALF_RST = 32'h03B9_ACA0; // 250 ms half period
    localparam logic [31:0] FAST_HALF_RST = 32'h00EE_6B28; // 62.5 ms half period

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_ASEL_LO   = 8'h04;
    localparam logic [7:0] OFS_ASEL_HI   = 8'h08;
    localparam logic [7:0] OFS_MIN_SCALE = 8'h0C;
    localparam logic [7:0] OFS_SLOW_HALF = 8'h10;
    localparam logic [7:0] OFS_FAST_HALF = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_TRIP0     = 8'h1C;
    localparam logic [7:0] OFS_TRIP3     = 8'h28;

    // Control register fields
    localparam int CTRL_AUTO  = 0;
    localparam int CTRL_3PH   = 1;
    localparam int CTRL_SSEL  = 2;   // Two bits
    localparam int CTRL_SRST  = 4;   // Write one: serial trip reset

    // Status register fields
    localparam int STAT_TRIP  = 0;
    localparam int STAT_LOCK  = 1;
    localparam int STAT_WARN  = 2;
    localparam int STAT_ARMED = 3;
    localparam int STAT_POWER = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Pin indices and fault codes
    localparam int PIN_LINE = 0;
    localparam int PIN_AUX  = 1;
    localparam int PIN_KEY  = 2;
    localparam int PIN_DIN  = 3;
    localparam int PIN_BFIT = 4;
    localparam int PIN_BOK  = 5;
    localparam int PIN_BLOC = 6;
    localparam int PIN_BNOM = 7;
    localparam int N_PINS   = 8;
    localparam int N_CODES  = 128;
    localparam int N_SEL    = 64;
    localparam int CODE_LIVE_ZERO = 2;
    localparam int CODE_PHASE     = 4;
    localparam int CODE_VHIGH     = 5;
    localparam int CODE_OVERVOLT  = 7;

    // Class bits returned by fault_class
    localparam int CLS_W = 0;
    localparam int CLS_A = 1;
    localparam int CLS_L = 2;

    // Warning, alarm and trip-lock capability of each fault code
    function automatic logic [2:0] fault_class(input logic [6:0] code);
        case (code)
            7'h02, 7'h04, 7'h07, 7'h08, 7'h0D: fault_class = 3'h7;
            7'h05, 7'h06, 7'h21, 7'h63: fault_class = 3'h1;
            7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h11, 7'h12, 7'h22, 7'h24: fault_class = 3'h3;
            7'h0E, 7'h0F, 7'h10, 7'h23: fault_class = 3'h6;
            7'h32, 7'h33, 7'h36, 7'h37, 7'h38: fault_class = 3'h2;
            default: fault_class = (code >= 7'h25 && code <= 7'h2D) ? 3'h6 : 3'h0;
        endcase
    endfunction : fault_class

    // Byte-lane merge of a register write
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  strb);
        for (int b = 0; b < 4; b++) begin
            wmerge[b*8 +: 8] = strb[b] ? dat[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : wmerge

endpackage : drive_fault_pkg

// file: panel_model.sv
// Panel and bus option model driving the drive's pins.
// Assumes bench requests are one-cycle pulses on clk.
`timescale 1ns/10ps
`default_nettype none
module panel_model (
    // Bench side
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       key_req,
    input  wire logic       din_req,
    input  wire logic       line_on,
    input  wire logic       aux_on,
    input  wire logic [1:0] bus_mode,
    // Drive side
    output logic [7:0]      pin_raw
);
    logic [3:0] key_cnt;
    logic [3:0] din_cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            key_cnt <= 4'h0;
            din_cnt <= 4'h0;
        end else begin
            key_cnt <= key_req ? 4'h8 : key_cnt - 4'(key_cnt != 4'h0);
            din_cnt <= din_req ? 4'h8 : din_cnt - 4'(din_cnt != 4'h0);
        end
    end
    assign pin_raw = {bus_mode == 2'h3, bus_mode == 2'h2, bus_mode == 2'h1, bus_mode != 2'h0,
                      din_cnt != 4'h0, key_cnt != 4'h0, aux_on, line_on};
endmodule : panel_model
`default_nettype wire

// file: tb_top.sv
// Bench for the fault annunciator: bus, panel pins, fault codes.
// Assumes panel_model drives the pins; reads checked from a queue.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk=0, rstn=0, ce=1, aw=0, awr, wv=0, wr_, bv, br=0, ar=0, arr, rv, rr=0;
    logic [127:0] fr='0;
    logic [15:0] ain=16'hFFFF;
    logic [7:0] pins, awa=8'h0, ara=8'h0;
    logic [31:0] wd=32'h0, rd_;
    logic [1:0] brs, rrs, bm=2'h1;
    logic sl, bl, al, wl, pl, coast, ready, kq=0, dq=0, ln=1, ax=0;
    int n_mismatch, samples_checked, ta, tw, tb;
    logic [34:0] notes[$], nt;
    logic [1:0] bnotes[$];
    int lo[4]='{0,0,15,31};
    int cs[3]='{6,33,99};
    always #2 clk = ~clk;
    drive_fault_annunciator #(.esc_cycles(20), .ain_width(16)) dut (.clk(clk), .rstn(rstn),
        .ce(ce), .fault_raw(fr), .pin_raw(pins), .ain_level(ain), .awaddr(awa), .awvalid(aw),
        .awready(awr), .wdata(wd), .wstrb(4'hF), .wvalid(wv), .wready(wr_), .bresp(brs),
        .bvalid(bv), .bready(br), .araddr(ara), .arvalid(ar), .arready(arr), .rdata(rd_),
        .rresp(rrs), .rvalid(rv), .rready(rr), .status_led(sl), .bus_led(bl), .alarm_led(al),
        .warn_led(wl), .power_led(pl), .coast(coast), .ready(ready));
    panel_model pm (.clk(clk), .rstn(rstn), .key_req(kq), .din_req(dq), .line_on(ln),
        .aux_on(ax), .bus_mode(bm), .pin_raw(pins));
    task automatic check(input logic [63:0] s, input logic [63:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // Counts LED changes over n cycles
    task automatic run(input int n);
        logic pa, pw, pb;
        {pa, pw, pb, ta, tw, tb} = {al, wl, bl, 96'h0};
        repeat (n) begin
            @(posedge clk);
            #1;
            ta += int'(al !== pa); tw += int'(wl !== pw); tb += int'(bl !== pb);
            {pa, pw, pb} = {al, wl, bl};
        end
    endtask : run
    // Each request starts one edge on, so no strobe is driven twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk);
        bnotes.push_back(e);
        awa <= a; wd <= d; aw <= 1'b1; wv <= 1'b1; br <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) aw <= 1'b0;
            if (wr_) wv <= 1'b0;
            if (bv) break;
        end
        br <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic c, input logic [1:0] e,
                      input logic [31:0] d);
        @(posedge clk);
        notes.push_back({c, e, d});
        ara <= a; ar <= 1'b1; rr <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) ar <= 1'b0;
            if (rv) break;
        end
        rr <= 1'b0;
    endtask : rd
    task automatic pulse(input logic k);
        if (k) kq <= 1; else dq <= 1;
        @(posedge clk);
        {kq, dq} <= 2'h0;
        wt(20);
    endtask : pulse
    // Bus answers against the oldest notes; an answer with no note counts
    always @(posedge clk) begin
        if (rv && rr) begin
            if (notes.size() == 0) begin
                n_mismatch++;
            end else begin
                nt = notes.pop_front();
                check(rrs, nt[33:32]);
                if (nt[34]) check(rd_, nt[31:0]);
            end
        end
        if (bv && br) begin
            if (bnotes.size() == 0) begin
                n_mismatch++;
            end else begin
                check(brs, bnotes.pop_front());
            end
        end
    end
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
    initial begin
        void'($urandom(32'hBAAE));
        wt(5);
        rstn <= 1'b1;
        // Supplies need the pin synchroniser before the power LED lights
        wt(12);
        check({ready, pl}, 2'h3);
        rd(8'h10, 1'b1, drive_fault_pkg::RESP_OKAY, drive_fault_pkg::SLOW_HALF_RST);
        rd(8'h40, 1'b0, drive_fault_pkg::RESP_SLVERR, 32'h0);
        wr(8'h40, 32'h5, drive_fault_pkg::RESP_SLVERR);
        wr(8'h10, 32'h3, 2'h0);
        wr(8'h14, 32'h1, 2'h0);
        rd(8'h10, 1'b1, 2'h0, 32'h3);
        wr(8'h00, 32'h0C, 2'h0);
        for (int m = 0; m < 4; m++) begin
            bm <= 2'(m);
            wt(12);
            run(64);
            check({tb >= lo[m], tb <= lo[m] + 2, m > 1 || bl === (m == 1)}, 3'h7);
        end
        bm <= 2'h1;
        check(sl, 1'b0);
        foreach (cs[i]) begin
            fr[cs[i]] <= 1'b1;
            wt(12);
            run(40);
            check({coast, tw != 0}, 2'h1);
            fr[cs[i]] <= 1'b0;
            wt(12);
            run(40);
            check(tw, 0);
        end
        for (int c = 14; c < 50; c += 26) begin
            fr[c] <= 1'b1;
            wt(12);
            run(40);
            check({coast, sl, ta != 0, tw != 0}, 4'hF);
            fr[c] <= 1'b0;
            pulse(1'b1);
            check(coast, 1'b1);
            {ln, ax} <= 2'h0;
            wt(12);
            check(pl, 1'b0);
            ax <= 1'b1;
            wt(12);
            check(pl, 1'b1);
            pulse(1'b1);
            check({coast, ready}, 2'h1);
            {ln, ax} <= 2'h2;
        end
        wr(8'h04, 32'h400, 2'h0);
        fr[10] <= 1'b1;
        wt(12);
        run(40);
        check({coast, ta != 0, tw != 0}, 3'h7);
        rd(8'h1C, 1'b1, 2'h0, 32'h400);
        fr[10] <= 1'b0;
        wt(12);
        run(40);
        check({ta != 0, tw != 0}, 2'h2);
        wr(8'h00, 32'h1C, 2'h0);
        wt(12);
        check(coast, 1'b0);
        wr(8'h04, 32'h0, 2'h0);
        fr[10] <= 1'b1;
        wt(12);
        run(40);
        check({coast, tw != 0}, 2'h1);
        fr[10] <= 1'b0;
        fr[5] <= 1'b1;
        wt(40);
        rd(8'h1C, 1'b1, 2'h0, 32'h80);
        check(coast, 1'b1);
        fr[5] <= 1'b0;
        {ln, ax} <= 2'h0;
        wt(12);
        ln <= 1'b1;
        pulse(1'b0);
        check(coast, 1'b0);
        wr(8'h00, 32'h0D, 2'h0);
        fr[50] <= 1'b1;
        wt(12);
        check(coast, 1'b1);
        fr[50] <= 1'b0;
        wt(12);
        check(coast, 1'b0);
        wr(8'h00, 32'h0C, 2'h0);
        fr[4] <= 1'b1;
        wt(12);
        run(40);
        check(tw, 0);
        wr(8'h00, 32'h0E, 2'h0);
        wt(12);
        run(40);
        check(tw != 0, 1'b1);
        fr[4] <= 1'b0;
        wr(8'h0C, 32'h64, 2'h0);
        ain <= 16'($urandom % 50);
        wt(12);
        run(40);
        check(tw != 0, 1'b1);
        ain <= 16'h32;
        wt(12);
        run(40);
        check(tw, 0);
        // Enable low freezes the fault path; the trip lands once it returns
        ce <= 1'b0;
        fr[14] <= 1'b1;
        wt(12);
        check(coast, 1'b0);
        ce <= 1'b1;
        wt(12);
        check(coast, 1'b1);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
